// ---- dv/lvpm_checker.sv ----
`timescale 1ns/10ps
// Port-side watcher for the power management registers
module lvpm_checker (
  input wire       i_mclk,
  input wire       i_rst,
  input wire       i_por,
  input wire       i_sys_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       i_undervoltage_detect,
  input wire       i_undervoltage_warning,
  input wire       i_stop2_recovered,
  input wire       o_detect_reset_req,
  input wire       o_detect_active,
  input wire [1:0] o_trip_code
);
  // Sync resets may clear flags, so they void the set-then-read checks
  wire quiet = !i_por && !i_sys_rst;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  warn_set_a: assert property ((i_undervoltage_warning && quiet) ##1
    (i_rd && i_addr == 4'h0 && quiet) |=> o_rdata[7]) else $error("warning flag not set");
  warn_ack_a: assert property ((i_wr && i_addr == 4'h0 && i_wdata[6] &&
    i_undervoltage_warning && quiet) ##1 (quiet && !i_wr) ##1
    (i_rd && i_addr == 4'h0 && quiet) |=> o_rdata[7]) else $error("ack cleared live warning");
  recov_set_a: assert property ((i_stop2_recovered && quiet) ##1
    (i_rd && i_addr == 4'h1 && quiet) |=> o_rdata[3]) else $error("recovery flag not set");
  ack_zero_a: assert property (i_rd && i_addr == 4'h1 |=>
    o_rdata[2:1] == 2'b00 && o_rdata[7:6] == 2'b00) else $error("stop reg zero bits set");
  rstreq_cause_a: assert property (o_detect_reset_req |->
    $past(i_undervoltage_detect)) else $error("reset request without detect");
  rstreq_live_a: assert property (o_detect_reset_req |->
    $past(o_detect_active) || o_detect_active) else $error("reset request while inactive");
  por_trip_a: assert property (i_por |-> ##[1:2] o_trip_code == 2'b00)
    else $error("trip code kept over power-on");
  sys_trip_a: assert property (i_sys_rst && !i_por && !i_wr && !$past(i_wr) |=>
    $stable(o_trip_code)) else $error("trip code lost on system reset");
  cover property (o_detect_reset_req);
  cover property (i_sys_rst);
  cover property (i_rd && i_addr == 4'h1 ##1 o_rdata[3]);
endmodule // lvpm_checker

bind lvpm_regs lvpm_checker chk_u (.i_mclk, .i_rst, .i_por, .i_sys_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_undervoltage_detect, .i_undervoltage_warning,
  .i_stop2_recovered, .o_detect_reset_req, .o_detect_active, .o_trip_code);

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic       i_mclk, i_rst, i_por, i_sys_rst, i_wr, i_rd, i_in_stop;
  logic       i_undervoltage_detect, i_undervoltage_warning, i_stop2_recovered;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  wire  [7:0] o_rdata;
  wire  [1:0] o_trip_code;
  wire        o_warn_irq_req, o_detect_reset_req, o_detect_active;
  wire        o_bandgap_buf_en, o_deep_stop_select, o_irq;
  int         error_cnt = 0;
  int         num_checks = 0;
  // Rows: address, write data, expected read-back
  logic [19:0] rows [10] = '{20'h02121, 20'h03d21, 20'h00101, 20'h02121, 20'h13131,
    20'h10421, 20'h30707, 20'h5ff00, 20'h2ff00, 20'h30000};

  lvpm_regs dut_u (.i_mclk, .i_rst, .i_por, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_undervoltage_detect, .i_undervoltage_warning, .i_in_stop,
    .i_stop2_recovered, .o_warn_irq_req, .o_detect_reset_req, .o_detect_active,
    .o_bandgap_buf_en, .o_trip_code, .o_deep_stop_select, .o_irq);

  // Free-running 50 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task wr(input [3:0] a, input [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input [3:0] a, input [7:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Whole run is well under two hundred cycles
  initial begin
    #100us;
    error_cnt++;
    conclude();
  end

  initial begin
    {i_por, i_sys_rst, i_wr, i_rd, i_in_stop, i_stop2_recovered} = '0;
    {i_undervoltage_detect, i_undervoltage_warning} = '0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_rst = 1'b1;
    repeat (8) @(posedge i_mclk);
    `CHK(o_irq, 1'b0)
    i_rst <= 1'b0;
    // Power-on pulse gives the documented write-once values
    @(posedge i_mclk);
    i_por <= 1'b1;
    @(posedge i_mclk);
    i_por <= 1'b0;
    rd(4'h0, 8'h1c);
    rd(4'h1, 8'h00);
    `CHK(o_detect_active, 1'b1)
    for (int k = 0; k < 10; k++) begin
      wr(rows[k][19:16], rows[k][15:8]);
      rd(rows[k][19:16], rows[k][7:0]);
    end
    `CHK(o_bandgap_buf_en, 1'b1)
    `CHK(o_trip_code, 2'b10)
    `CHK(o_deep_stop_select, 1'b1)
    // Warning with interrupt masked, then unmasked, ack refused then taken
    @(posedge i_mclk);
    i_undervoltage_warning <= 1'b1;
    cyc(3);
    rd(4'h0, 8'ha1);
    `CHK(o_warn_irq_req, 1'b1)
    `CHK(o_irq, 1'b0)
    wr(4'h3, 8'h07);
    cyc(2);
    `CHK(o_irq, 1'b1)
    wr(4'h0, 8'h61);
    rd(4'h0, 8'ha1);
    @(posedge i_mclk);
    i_undervoltage_warning <= 1'b0;
    wr(4'h0, 8'h61);
    rd(4'h0, 8'h21);
    wr(4'h2, 8'h07);
    cyc(2);
    `CHK(o_warn_irq_req, 1'b0)
    `CHK(o_irq, 1'b0)
    // Stop2 recovery flag, write to it ignored, ack clears it
    @(posedge i_mclk);
    i_stop2_recovered <= 1'b1;
    rd(4'h1, 8'h29);
    @(posedge i_mclk);
    i_stop2_recovered <= 1'b0;
    wr(4'h1, 8'h2c);
    rd(4'h1, 8'h21);
    // Detect ignored while detection is off
    @(posedge i_mclk);
    i_undervoltage_detect <= 1'b1;
    cyc(3);
    `CHK(o_detect_reset_req, 1'b0)
    @(posedge i_mclk);
    i_undervoltage_detect <= 0;
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd(4'h0, 8'h1c);
    rd(4'h1, 8'h20);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h20);
    @(posedge i_mclk);
    i_undervoltage_detect <= 1'b1;
    cyc(2);
    `CHK(o_detect_reset_req, 1'b1)
    @(posedge i_mclk);
    i_undervoltage_detect <= 1'b0;
    // Stop mode without stop operation enabled
    wr(4'h0, 8'h14);
    @(posedge i_mclk);
    i_in_stop <= 1'b1;
    cyc(2);
    `CHK(o_detect_active, 1'b0)
    @(posedge i_mclk);
    i_undervoltage_detect <= 1'b1;
    cyc(2);
    `CHK(o_detect_reset_req, 1'b0)
    @(posedge i_mclk);
    i_por <= 1'b1;
    @(posedge i_mclk);
    i_por <= 1'b0;
    rd(4'h1, 8'h00);
    `CHK(o_trip_code, 2'b00)
    // Power-on restores stop operation, so detection stays live in stop
    `CHK(o_detect_active, 1'b1)
    `CHK(o_detect_reset_req, 1'b1)
    // Recovery and detect events left their sticky status bits
    rd(4'h2, 8'h06);
    conclude();
  end
endmodule // tb_top

// ---- logic/lvpm_consts.vh ----
`ifndef LVPM_CONSTS_VH
`define LVPM_CONSTS_VH

// Register word offsets (byte addresses on the plain port)
`define LVPM_ADDR_W          4
`define LVPM_OFS_CTRL        4'h0
`define LVPM_OFS_STOP        4'h1
`define LVPM_OFS_IRQ_STAT    4'h2
`define LVPM_OFS_IRQ_MASK    4'h3

// Control register fields
`define LVPM_B_WARN_FLAG     7
`define LVPM_B_WARN_ACK      6
`define LVPM_B_WARN_IRQ_EN   5
`define LVPM_B_DET_RST_EN    4
`define LVPM_B_DET_STOP_EN   3
`define LVPM_B_DET_EN        2
`define LVPM_B_BGBUF_EN      0

// Stop and trip select register fields
`define LVPM_B_DET_LVL       5
`define LVPM_B_WARN_LVL      4
`define LVPM_B_DS_RECOV      3
`define LVPM_B_DS_ACK        2
`define LVPM_B_DS_SEL        0

// Interrupt status and mask bits
`define LVPM_IRQ_W           3
`define LVPM_I_WARN          0
`define LVPM_I_DETECT        1
`define LVPM_I_DS_RECOV      2

// Reset values
`define LVPM_CTRL_RST        8'h1c
`define LVPM_STOP_RST        8'h00
`define LVPM_MASK_RST        3'h0

`endif

// ---- logic/lvpm_regs.v ----
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "lvpm_consts.vh"
// How it works
// - The warning flag sets when the warning comparator shows low supply, also right after reset.
// - Writing one to warn_ack clears the flag only while the warning level is gone.
// - With warn_irq_en set, a set warning flag raises the warning interrupt request.
// - Write-once detect_reset_en with detect_en makes a detect event force a system reset.
// - Write-once detect_stop_en keeps detection running in stop mode when detect_en is set.
// - Write-once detect_en turns detection on and qualifies the reset and stop bits.
// - Control bit 0 drives the bandgap buffer enable.
// - Every write-once bit keeps only its first write after reset.
// - The detect level select is write-once per power-on; both level selects survive other resets.
// - Detect and warning selects form the two-bit trip code for the comparators.
// - deep_stop_recovered sets on recovery from stop2 and ignores writes.
// - Writing one to deep_stop_ack clears deep_stop_recovered; the ack reads zero.
// - Write-once deep_stop_select chooses stop2 when one and stop3 when zero.
module lvpm_regs (
  input  wire                    i_mclk,
  input  wire                    i_rst,
  input  wire                    i_por,
  input  wire                    i_sys_rst,
  input  wire [`LVPM_ADDR_W-1:0] i_addr,
  input  wire [7:0]              i_wdata,
  input  wire                    i_wr,
  input  wire                    i_rd,
  output reg  [7:0]              o_rdata,
  input  wire                    i_undervoltage_detect,
  input  wire                    i_undervoltage_warning,
  input  wire                    i_in_stop,
  input  wire                    i_stop2_recovered,
  output reg                     o_warn_irq_req,
  output reg                     o_detect_reset_req,
  output reg                     o_detect_active,
  output reg                     o_bandgap_buf_en,
  output reg  [1:0]              o_trip_code,
  output reg                     o_deep_stop_select,
  output reg                     o_irq
);
  reg                   warn_flag_reg;
  reg                   warn_irq_en_reg;
  reg                   bgbuf_reg;
  reg                   warn_lvl_reg;
  reg                   ds_recov_reg;
  reg [`LVPM_IRQ_W-1:0] irq_stat_reg;
  reg [`LVPM_IRQ_W-1:0] irq_mask_reg;
  reg [`LVPM_IRQ_W-1:0] irq_stat_next;
  reg                   first_reg;
  reg [7:0]             rdata_next;

  wire wr_ctrl = i_wr && (i_addr == `LVPM_OFS_CTRL);
  wire wr_stop = i_wr && (i_addr == `LVPM_OFS_STOP);
  wire any_rst = i_por | i_sys_rst;

  // Write decodes for the interrupt registers
  wire wr_stat = i_wr && (i_addr == `LVPM_OFS_IRQ_STAT);
  wire wr_mask = i_wr && (i_addr == `LVPM_OFS_IRQ_MASK);

  // Write-once outputs

  wire det_en;
  wire det_rst_en;
  wire det_stop_en;
  wire ds_sel;
  wire det_lvl;

  // Write-once bits; cleared by any reset except the POR-only level select
  lvpm_wonce u_det_en (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_clr     (any_rst),
    .i_rst_val (1'b1),
    .i_wr      (wr_ctrl),
    .i_wdata   (i_wdata[`LVPM_B_DET_EN]),
    .o_val     (det_en)
  );
  lvpm_wonce u_det_rst_en (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_clr     (any_rst),
    .i_rst_val (1'b1),
    .i_wr      (wr_ctrl),
    .i_wdata   (i_wdata[`LVPM_B_DET_RST_EN]),
    .o_val     (det_rst_en)
  );
  lvpm_wonce u_det_stop_en (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_clr     (any_rst),
    .i_rst_val (1'b1),
    .i_wr      (wr_ctrl),
    .i_wdata   (i_wdata[`LVPM_B_DET_STOP_EN]),
    .o_val     (det_stop_en)
  );
  lvpm_wonce u_ds_sel (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_clr     (any_rst),
    .i_rst_val (1'b0),
    .i_wr      (wr_stop),
    .i_wdata   (i_wdata[`LVPM_B_DS_SEL]),
    .o_val     (ds_sel)
  );
  lvpm_wonce u_det_lvl (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_clr     (i_por),
    .i_rst_val (1'b0),
    .i_wr      (wr_stop),
    .i_wdata   (i_wdata[`LVPM_B_DET_LVL]),
    .o_val     (det_lvl)
  );

  // Detection qualified by enable and stop state
  wire det_live  = det_en && (!i_in_stop || det_stop_en);
  wire det_event = det_live && i_undervoltage_detect;

  wire warn_ack_ok = wr_ctrl && i_wdata[`LVPM_B_WARN_ACK] && !i_undervoltage_warning;
  wire ds_ack      = wr_stop && i_wdata[`LVPM_B_DS_ACK];

  // Warning flag: live warning always wins over the acknowledge
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      warn_flag_reg <= 1'b0;
    end else if (i_undervoltage_warning) begin
      warn_flag_reg <= 1'b1;
    end else if (any_rst) begin
      warn_flag_reg <= 1'b0;
    end else if (warn_ack_ok) begin
      warn_flag_reg <= 1'b0;
    end
  end

  // Plain control bits, lost on any reset
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      warn_irq_en_reg <= 1'b0;
      bgbuf_reg       <= 1'b0;
    end else if (any_rst) begin
      warn_irq_en_reg <= 1'b0;
      bgbuf_reg       <= 1'b0;
    end else if (wr_ctrl) begin
      warn_irq_en_reg <= i_wdata[`LVPM_B_WARN_IRQ_EN];
      bgbuf_reg       <= i_wdata[`LVPM_B_BGBUF_EN];
    end
  end

  // Warning level select survives all but power-on
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      warn_lvl_reg <= 1'b0;
    end else if (i_por) begin
      warn_lvl_reg <= 1'b0;
    end else if (wr_stop) begin
      warn_lvl_reg <= i_wdata[`LVPM_B_WARN_LVL];
    end
  end

  // Stop2 recovery flag; the recovery event beats the ack
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ds_recov_reg <= 1'b0;
    end else if (i_stop2_recovered) begin
      ds_recov_reg <= 1'b1;
    end else if (any_rst || ds_ack) begin
      ds_recov_reg <= 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_reg & ~i_wdata[`LVPM_IRQ_W-1:0];
    end
    if (warn_flag_reg) begin
      irq_stat_next[`LVPM_I_WARN] = 1'b1;
    end
    if (det_event) begin
      irq_stat_next[`LVPM_I_DETECT] = 1'b1;
    end
    if (i_stop2_recovered) begin
      irq_stat_next[`LVPM_I_DS_RECOV] = 1'b1;
    end
  end

  // Status and mask registers
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_reg <= {`LVPM_IRQ_W{1'b0}};
      irq_mask_reg <= `LVPM_MASK_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_mask) begin
        irq_mask_reg <= i_wdata[`LVPM_IRQ_W-1:0];
      end
    end
  end

  // Read mux; acks always read zero
  always @* begin
    case (i_addr)
      `LVPM_OFS_CTRL: begin
        rdata_next = {warn_flag_reg, 1'b0, warn_irq_en_reg, det_rst_en,
                      det_stop_en, det_en, 1'b0, bgbuf_reg};
      end
      `LVPM_OFS_STOP: begin
        rdata_next = {2'b00, det_lvl, warn_lvl_reg, ds_recov_reg, 2'b00, ds_sel};
      end
      `LVPM_OFS_IRQ_STAT: begin
        rdata_next = {5'h00, irq_stat_reg};
      end
      `LVPM_OFS_IRQ_MASK: begin
        rdata_next = {5'h00, irq_mask_reg};
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read data stands for one cycle only, zero otherwise
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rdata_next : 8'h00;
    end
  end

  // Warning interrupt request follows the flag one cycle late
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_warn_irq_req <= 1'b0;
    end else begin
      o_warn_irq_req <= warn_irq_en_reg && warn_flag_reg;
    end
  end

  // Marks the first edge after the async reset
  // Blocks a spurious reset request while the write-once bits settle
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      first_reg <= 1'b0;
    end else begin
      first_reg <= 1'b1;
    end
  end

  // Reset request, one cycle per qualified detect cycle
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_detect_reset_req <= 1'b0;
    end else begin
      o_detect_reset_req <= det_event && det_rst_en && first_reg;
    end
  end

  // Detection live flag for the analog side
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_detect_active <= 1'b0;
    end else begin
      o_detect_active <= det_live;
    end
  end

  // Bandgap buffer enable; an idle buffer only wastes current
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_bandgap_buf_en <= 1'b0;
    end else begin
      o_bandgap_buf_en <= bgbuf_reg;
    end
  end

  // Trip code to the comparators
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_trip_code <= 2'b00;
    end else begin
      o_trip_code <= {det_lvl, warn_lvl_reg};
    end
  end

  // Stop mode choice for the power controller
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_deep_stop_select <= 1'b0;
    end else begin
      o_deep_stop_select <= ds_sel;
    end
  end

  // Interrupt line, high while any unmasked status bit is set
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule // lvpm_regs

// ---- logic/lvpm_wonce.v ----
`timescale 1ns/10ps
// One write-once bit: first write after clear is kept, later ones dropped
module lvpm_wonce (
  input  wire i_mclk,
  input  wire i_rst,
  input  wire i_clr,
  input  wire i_rst_val,
  input  wire i_wr,
  input  wire i_wdata,
  output wire o_val
);
  reg val_reg;
  reg done_reg;

  // Lock after the first write
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      val_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else if (i_clr) begin
      val_reg  <= i_rst_val;
      done_reg <= 1'b0;
    end else if (i_wr && !done_reg) begin
      val_reg  <= i_wdata;
      done_reg <= 1'b1;
    end
  end

  assign o_val = val_reg;
endmodule // lvpm_wonce
